// ==== hdl/pbfc_filter_ctrl.v ====
// playback filter control: registers, coefficient store and gain ramps
// Notes on behaviour
// - EQ enabled applies fixed 12 dB attenuation
// - EQ enable bit 7, reset 0
// - band five gain 4 bits, 1.5 dB steps, reset 7
// - biquad enable bit 7, reset off
// - biquad mute bit 6, reset muted
// - data byte written before address
// - six-bit coefficient address, reset 0
// - even address low, odd high byte
// - address write stores data byte
// - ramp bit 5: ramp else immediate
// - fine bit needs ramp bit
// - ramp plus fine gives four times slower steps
// - bit 3 routes path through biquad
`timescale 1ns/1ps
`default_nettype none
`include "pbfc_regs.vh"
module pbfc_filter_ctrl (
  input  wire        clk_sys,
  input  wire        nrst,
  input  wire [7:0]  regAddr,
  input  wire [7:0]  regWdata,
  input  wire        regWr,
  input  wire        regRd,
  output reg  [7:0]  regRdata_ff,
  output wire        equaliserEnable,
  output wire [3:0]  bandFiveGain,
  output wire [7:0]  eqAttenDb,
  output wire        biquadEnable,
  output wire        biquadMute,
  output wire        leftPathEnable,
  output wire        leftPathMute,
  output wire        leftBiquadSelect,
  output wire [7:0]  leftGain,
  output wire        leftRampBusy,
  output wire        rightPathEnable,
  output wire        rightPathMute,
  output wire        rightBiquadSelect,
  output wire [7:0]  rightGain,
  output wire        rightRampBusy,
  output reg         coefWrStrobe_ff,
  output reg  [4:0]  coefWrIndex_ff,
  output reg  [15:0] coefWrValue_ff
);
  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  reg [7:0]  leftCtrl_ff;
  reg [7:0]  rightCtrl_ff;
  reg [7:0]  eqCtrl_ff;
  reg [7:0]  biqCtrl_ff;
  reg [7:0]  coefData_ff;
  reg [5:0]  coefAddr_ff;
  reg [7:0]  gainL_ff;
  reg [7:0]  gainR_ff;
  reg [7:0]  coefMem [0:63];
  reg [7:0]  nxt_leftCtrl;
  reg [7:0]  nxt_rightCtrl;
  reg [7:0]  nxt_eqCtrl;
  reg [7:0]  nxt_biqCtrl;
  reg [7:0]  nxt_coefData;
  reg [5:0]  nxt_coefAddr;
  reg [7:0]  nxt_gainL;
  reg [7:0]  nxt_gainR;
  reg [4:0]  nxt_coefWrIndex;
  reg [15:0] nxt_coefWrValue;
  reg [7:0]  nxt_regRdata;
  wire [7:0] curGainL;
  wire [7:0] curGainR;
  wire       wrLeft;
  wire       wrRight;
  wire       wrEq;
  wire       wrBiq;
  wire       wrData;
  wire       wrAddr;
  wire       wrGainL;
  wire       wrGainR;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  // unmapped offsets decode to nothing, so such writes are dropped
  assign wrLeft  = regWr && (regAddr == `PBFC_ADDR_LEFT);
  assign wrRight = regWr && (regAddr == `PBFC_ADDR_RIGHT);
  assign wrEq    = regWr && (regAddr == `PBFC_ADDR_EQ5);
  assign wrBiq   = regWr && (regAddr == `PBFC_ADDR_BIQ_CTRL);
  assign wrData  = regWr && (regAddr == `PBFC_ADDR_BIQ_DATA);
  assign wrAddr  = regWr && (regAddr == `PBFC_ADDR_BIQ_ADDR);
  assign wrGainL = regWr && (regAddr == `PBFC_ADDR_GAIN_L);
  assign wrGainR = regWr && (regAddr == `PBFC_ADDR_GAIN_R);

  // ------------------------------------------------------------
  // next control values
  // ------------------------------------------------------------
  always @* begin
    // hold every field unless its offset is written
    nxt_leftCtrl  = leftCtrl_ff;
    nxt_rightCtrl = rightCtrl_ff;
    nxt_eqCtrl    = eqCtrl_ff;
    nxt_biqCtrl   = biqCtrl_ff;
    nxt_coefData  = coefData_ff;
    nxt_coefAddr  = coefAddr_ff;
    nxt_gainL     = gainL_ff;
    nxt_gainR     = gainR_ff;

    if (wrLeft) begin
      nxt_leftCtrl = {regWdata[7:3], 3'h0};
    end
    if (wrRight) begin
      nxt_rightCtrl = {regWdata[7:3], 3'h0};
    end
    if (wrEq) begin
      nxt_eqCtrl = {regWdata[7], 3'h0, regWdata[3:0]};
    end
    if (wrBiq) begin
      nxt_biqCtrl = {regWdata[7:6], 6'h00};
    end
    if (wrData) begin
      nxt_coefData = regWdata;
    end
    if (wrAddr) begin
      nxt_coefAddr = regWdata[5:0];
    end
    if (wrGainL) begin
      nxt_gainL = regWdata;
    end
    if (wrGainR) begin
      nxt_gainR = regWdata;
    end
  end

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!nrst) begin
      leftCtrl_ff  <= `PBFC_RST_PATH;
      rightCtrl_ff <= `PBFC_RST_PATH;
      eqCtrl_ff    <= `PBFC_RST_EQ5;
      biqCtrl_ff   <= `PBFC_RST_BIQ_CTRL;
      coefData_ff  <= `PBFC_RST_ZERO;
      coefAddr_ff  <= 6'h00;
      gainL_ff     <= `PBFC_RST_GAIN;
      gainR_ff     <= `PBFC_RST_GAIN;
    end else begin
      leftCtrl_ff  <= nxt_leftCtrl;
      rightCtrl_ff <= nxt_rightCtrl;
      eqCtrl_ff    <= nxt_eqCtrl;
      biqCtrl_ff   <= nxt_biqCtrl;
      coefData_ff  <= nxt_coefData;
      coefAddr_ff  <= nxt_coefAddr;
      gainL_ff     <= nxt_gainL;
      gainR_ff     <= nxt_gainR;
    end
  end

  // ------------------------------------------------------------
  // coefficient store
  // ------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (wrAddr) begin
      coefMem[regWdata[5:0]] <= coefData_ff;
    end
  end

  // ------------------------------------------------------------
  // coefficient output
  // ------------------------------------------------------------
  // the partner byte comes from the store, so one write per byte suffices
  always @* begin
    nxt_coefWrIndex = coefWrIndex_ff;
    nxt_coefWrValue = coefWrValue_ff;
    if (wrAddr) begin
      nxt_coefWrIndex = regWdata[5:1];
      if (regWdata[0]) begin
        nxt_coefWrValue = {coefData_ff, coefMem[{regWdata[5:1], 1'b0}]};
      end else begin
        nxt_coefWrValue = {coefMem[{regWdata[5:1], 1'b1}], coefData_ff};
      end
    end
  end

  always @(posedge clk_sys) begin
    if (!nrst) begin
      coefWrStrobe_ff <= 1'b0;
      coefWrIndex_ff  <= 5'h00;
      coefWrValue_ff  <= 16'h0000;
    end else begin
      coefWrStrobe_ff <= wrAddr;
      coefWrIndex_ff  <= nxt_coefWrIndex;
      coefWrValue_ff  <= nxt_coefWrValue;
    end
  end

  // ------------------------------------------------------------
  // gain ramps
  // ------------------------------------------------------------
  // ramp or immediate gain
  pbfc_gain_ramp uRampL (
    .clk_sys    (clk_sys),
    .nrst       (nrst),
    .rampEn     (leftCtrl_ff[`PBFC_BIT_PATH_RAMP]),
    .fineEn     (leftCtrl_ff[`PBFC_BIT_PATH_FINE]),
    .targetGain (gainL_ff),
    .curGain_ff (curGainL),
    .rampBusy   (leftRampBusy)
  );

  pbfc_gain_ramp uRampR (
    .clk_sys    (clk_sys),
    .nrst       (nrst),
    .rampEn     (rightCtrl_ff[`PBFC_BIT_PATH_RAMP]),
    .fineEn     (rightCtrl_ff[`PBFC_BIT_PATH_FINE]),
    .targetGain (gainR_ff),
    .curGain_ff (curGainR),
    .rampBusy   (rightRampBusy)
  );

  // ------------------------------------------------------------
  // control outputs
  // ------------------------------------------------------------
  assign equaliserEnable   = eqCtrl_ff[`PBFC_BIT_EQ_EN];
  assign bandFiveGain      = eqCtrl_ff[3:0];
  assign eqAttenDb         = equaliserEnable ? `PBFC_EQ_ATTEN_DB : 8'h00;
  assign biquadEnable      = biqCtrl_ff[`PBFC_BIT_BIQ_EN];
  assign biquadMute        = biqCtrl_ff[`PBFC_BIT_BIQ_MUTE];
  assign leftPathEnable    = leftCtrl_ff[`PBFC_BIT_PATH_EN];
  assign leftPathMute      = leftCtrl_ff[`PBFC_BIT_PATH_MUTE];
  assign leftBiquadSelect  = leftCtrl_ff[`PBFC_BIT_PATH_BIQ];
  assign leftGain          = curGainL;
  assign rightPathEnable   = rightCtrl_ff[`PBFC_BIT_PATH_EN];
  assign rightPathMute     = rightCtrl_ff[`PBFC_BIT_PATH_MUTE];
  assign rightBiquadSelect = rightCtrl_ff[`PBFC_BIT_PATH_BIQ];
  assign rightGain         = curGainR;

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  // unmapped and reserved reads return zero
  always @* begin
    nxt_regRdata = 8'h00;
    if (regRd) begin
      case (regAddr)
        `PBFC_ADDR_LEFT:       nxt_regRdata = leftCtrl_ff;
        `PBFC_ADDR_RIGHT:      nxt_regRdata = rightCtrl_ff;
        `PBFC_ADDR_EQ5:        nxt_regRdata = eqCtrl_ff;
        `PBFC_ADDR_BIQ_CTRL:   nxt_regRdata = biqCtrl_ff;
        `PBFC_ADDR_BIQ_DATA:   nxt_regRdata = coefData_ff;
        `PBFC_ADDR_BIQ_ADDR:   nxt_regRdata = {2'h0, coefAddr_ff};
        `PBFC_ADDR_GAIN_L:     nxt_regRdata = gainL_ff;
        `PBFC_ADDR_GAIN_R:     nxt_regRdata = gainR_ff;
        `PBFC_ADDR_COEF_RD:    nxt_regRdata = coefMem[coefAddr_ff];
        `PBFC_ADDR_CUR_GAIN_L: nxt_regRdata = curGainL;
        `PBFC_ADDR_CUR_GAIN_R: nxt_regRdata = curGainR;
        default:               nxt_regRdata = 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------
  // read data register
  // ------------------------------------------------------------
  // data stand only in the cycle after the strobe, zero otherwise
  always @(posedge clk_sys) begin
    if (!nrst) begin
      regRdata_ff <= 8'h00;
    end else begin
      regRdata_ff <= nxt_regRdata;
    end
  end
endmodule // pbfc_filter_ctrl
`default_nettype wire

// ==== hdl/pbfc_gain_ramp.v ====
// gain ramp engine of one output path
`timescale 1ns/1ps
`default_nettype none
`include "pbfc_regs.vh"
module pbfc_gain_ramp (
  input  wire       clk_sys,
  input  wire       nrst,
  input  wire       rampEn,
  input  wire       fineEn,
  input  wire [7:0] targetGain,
  output reg  [7:0] curGain_ff,
  output wire       rampBusy
);
  reg [5:0] tick_ff;
  reg [1:0] sub_ff;
  wire      tickDone = (tick_ff == `PBFC_RAMP_LAST);
  wire      subDone  = (sub_ff == `PBFC_FINE_LAST);
  assign rampBusy = (curGain_ff != targetGain);
  always @(posedge clk_sys) begin
    if (!nrst) begin
      curGain_ff <= `PBFC_RST_GAIN;
      tick_ff    <= 6'h00;
      sub_ff     <= 2'h0;
    end else if (!rampEn) begin
      curGain_ff <= targetGain;
      tick_ff    <= 6'h00;
      sub_ff     <= 2'h0;
    end else if (rampBusy) begin
      tick_ff <= tickDone ? 6'h00 : tick_ff + 6'h01;
      if (tickDone) begin
        sub_ff <= fineEn ? sub_ff + 2'h1 : 2'h0;
        if (!fineEn || subDone) begin
          if (curGain_ff < targetGain) begin
            curGain_ff <= curGain_ff + 8'h01;
          end else begin
            curGain_ff <= curGain_ff - 8'h01;
          end
        end
      end
    end else begin
      tick_ff <= 6'h00;
      sub_ff  <= 2'h0;
    end
  end
endmodule // pbfc_gain_ramp
`default_nettype wire

// ==== hdl/pbfc_regs.vh ====
// register offsets, field positions, reset values and timing counts of the playback filter control
`ifndef PBFC_REGS_VH
`define PBFC_REGS_VH
`define PBFC_ADDR_LEFT        8'h20
`define PBFC_ADDR_RIGHT       8'h21
`define PBFC_ADDR_EQ5         8'h27
`define PBFC_ADDR_BIQ_CTRL    8'h28
`define PBFC_ADDR_BIQ_DATA    8'h29
`define PBFC_ADDR_BIQ_ADDR    8'h2A
`define PBFC_ADDR_GAIN_L      8'h30
`define PBFC_ADDR_GAIN_R      8'h31
`define PBFC_ADDR_COEF_RD     8'h32
`define PBFC_ADDR_CUR_GAIN_L  8'h33
`define PBFC_ADDR_CUR_GAIN_R  8'h34
`define PBFC_BIT_PATH_EN      7
`define PBFC_BIT_PATH_MUTE    6
`define PBFC_BIT_PATH_RAMP    5
`define PBFC_BIT_PATH_FINE    4
`define PBFC_BIT_PATH_BIQ     3
`define PBFC_BIT_EQ_EN        7
`define PBFC_BIT_BIQ_EN       7
`define PBFC_BIT_BIQ_MUTE     6
`define PBFC_RST_PATH         8'h40
`define PBFC_RST_EQ5          8'h07
`define PBFC_RST_BIQ_CTRL     8'h40
`define PBFC_RST_ZERO         8'h00
`define PBFC_RST_GAIN         8'h80
`define PBFC_EQ_ATTEN_DB      8'h0C
`define PBFC_RAMP_STEP_NS     1000
`define PBFC_CLK_NS           50
`define PBFC_RAMP_CYC         (`PBFC_RAMP_STEP_NS / `PBFC_CLK_NS)
`define PBFC_FINE_DIV         4
`define PBFC_RAMP_LAST        6'h13
`define PBFC_FINE_LAST        2'h3
`endif

// ==== verif/pbfc_filter_ctrl_asserts.sv ====
// port assertions of the playback filter control
`timescale 1ns/1ps
`default_nettype none
module pbfc_filter_ctrl_chk (
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic [7:0]  regAddr,
  input wire logic [7:0]  regWdata,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [7:0]  regRdata_ff,
  input wire logic        equaliserEnable,
  input wire logic [3:0]  bandFiveGain,
  input wire logic [7:0]  eqAttenDb,
  input wire logic        biquadEnable,
  input wire logic        biquadMute,
  input wire logic        leftPathEnable,
  input wire logic        leftPathMute,
  input wire logic        leftBiquadSelect,
  input wire logic [7:0]  leftGain,
  input wire logic        leftRampBusy,
  input wire logic        rightPathEnable,
  input wire logic        rightPathMute,
  input wire logic        rightBiquadSelect,
  input wire logic        coefWrStrobe_ff,
  input wire logic [4:0]  coefWrIndex_ff
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence wrTo(logic [7:0] a);
    regWr && regAddr == a;
  endsequence
  chk_eq_atten: assert property (eqAttenDb == (equaliserEnable ? 8'h0C : 8'h00))
    else $error("eq attenuation wrong");
  chk_eq_fields: assert property (wrTo(8'h27) |=> equaliserEnable ==
    $past(regWdata[7]) && bandFiveGain == $past(regWdata[3:0])) else $error("eq fields wrong");
  chk_biq_ctrl: assert property (wrTo(8'h28) |=> biquadEnable == $past(regWdata[7])
    && biquadMute == $past(regWdata[6])) else $error("biquad control wrong");
  chk_coef_store: assert property (wrTo(8'h2A) |=> coefWrStrobe_ff
    && coefWrIndex_ff == $past(regWdata[5:1])) else $error("coefficient store missing");
  chk_strobe_cause: assert property (coefWrStrobe_ff |-> $past(regWr && regAddr == 8'h2A))
    else $error("coefficient store without address write");
  chk_left_bits: assert property (wrTo(8'h20) |=> {leftPathEnable, leftPathMute,
    leftBiquadSelect} == {$past(regWdata[7:6]), $past(regWdata[3])})
    else $error("left bits wrong");
  chk_right_bits: assert property (wrTo(8'h21) |=> {rightPathEnable, rightPathMute,
    rightBiquadSelect} == {$past(regWdata[7:6]), $past(regWdata[3])})
    else $error("right bits wrong");
  chk_ramp_step: assert property ($past(leftRampBusy) && leftRampBusy |->
    leftGain == $past(leftGain) || leftGain == $past(leftGain) + 8'h01
    || leftGain == $past(leftGain) - 8'h01) else $error("ramp jumped");
  chk_read_idle: assert property (!$past(regRd) |-> regRdata_ff == 8'h00)
    else $error("read data outside read slot");
endmodule // pbfc_filter_ctrl_chk
bind pbfc_filter_ctrl pbfc_filter_ctrl_chk u_pbfc_filter_ctrl_chk (.*);
`default_nettype wire

// ==== verif/pbfc_filter_ctrl_bench.sv ====
// self-checking bench of the playback filter control
`timescale 1ns/1ps
`default_nettype none
module pbfc_filter_ctrl_bench;
  logic        clk_sys, nrst, regWr, regRd;
  logic [7:0]  regAddr, regWdata;
  wire  [7:0]  regRdata_ff, eqAttenDb, leftGain, rightGain;
  wire  [3:0]  bandFiveGain;
  wire  [4:0]  coefWrIndex_ff;
  wire  [15:0] coefWrValue_ff;
  wire         equaliserEnable, biquadEnable, biquadMute, leftPathEnable, leftPathMute;
  wire         leftBiquadSelect, leftRampBusy, rightPathEnable, rightPathMute;
  wire         rightBiquadSelect, rightRampBusy, coefWrStrobe_ff;
  int          bad_count = 0;
  int          n_compared = 0;
  pbfc_filter_ctrl u_pbfc_filter_ctrl (.*);
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1;
    check(regRdata_ff, exp);
  endtask
  task automatic end_of_test;
    $display("compared=%0d mismatches=%0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ramp to a new target, timing the settle against a window of cycles
  task automatic ramp_time(input logic [7:0] old, input logic [7:0] tgt,
                           input int lo, input int hi);
    int n;
    wr(8'h30, tgt);
    n = 0;
    check(leftGain, old);
    while (leftRampBusy !== 1'b0 && n < 1000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n >= 1000) begin
      bad_count++;
      end_of_test();
    end else begin
      check(leftGain, tgt);
      check(n > lo && n < hi, 1'b1);
    end
  endtask
  task automatic t_reset;
    logic [7:0] a [10] = '{8'h20, 8'h21, 8'h27, 8'h28, 8'h29, 8'h2A, 8'h30, 8'h31, 8'h33, 8'h34};
    logic [7:0] e [10] = '{8'h40, 8'h40, 8'h07, 8'h40, 8'h00, 8'h00, 8'h80, 8'h80, 8'h80, 8'h80};
    for (int i = 0; i < 10; i++) begin
      rd(a[i], e[i]);
    end
    rd(8'h50, 8'h00);
  endtask
  task automatic t_eq_biq;
    wr(8'h27, 8'h8F);
    check({equaliserEnable, bandFiveGain}, 5'h1F);
    check(eqAttenDb, 8'h0C);
    rd(8'h27, 8'h8F);
    wr(8'h27, 8'h00);
    check(eqAttenDb, 8'h00);
    wr(8'h28, 8'h80);
    check({biquadEnable, biquadMute}, 2'h2);
  endtask
  task automatic t_coef;
    wr(8'h29, 8'h34);
    check(coefWrStrobe_ff, 1'b0);
    wr(8'h2A, 8'h06);
    check({coefWrStrobe_ff, coefWrIndex_ff}, 6'h23);
    check(coefWrValue_ff[7:0], 8'h34);
    wr(8'h29, 8'h12);
    wr(8'h2A, 8'h07);
    check(coefWrValue_ff, 16'h1234);
    rd(8'h32, 8'h12);
    wr(8'h2A, 8'hFF);
    rd(8'h2A, 8'h3F);
  endtask
  task automatic t_paths;
    wr(8'h20, 8'h88);
    check({leftPathEnable, leftPathMute, leftBiquadSelect}, 3'h5);
    wr(8'h21, 8'h48);
    check({rightPathEnable, rightPathMute, rightBiquadSelect}, 3'h3);
    wr(8'h31, 8'h70);
    check(rightGain, 8'h80);
    @(posedge clk_sys);
    #1;
    check({rightRampBusy, rightGain}, 9'h070);
    rd(8'h34, 8'h70);
    wr(8'h30, 8'h90);
    @(posedge clk_sys);
    #1;
    check(leftGain, 8'h90);
    rd(8'h33, 8'h90);
    wr(8'h20, 8'h10);
    wr(8'h30, 8'h94);
    @(posedge clk_sys);
    #1;
    check(leftGain, 8'h94);
    wr(8'h20, 8'hA0);
    ramp_time(8'h94, 8'h96, 20, 60);
    wr(8'h20, 8'hB0);
    ramp_time(8'h96, 8'h94, 120, 200);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    nrst     = 1'b0;
    regWr    = 1'b0;
    regRd    = 1'b0;
    regAddr  = 8'h00;
    regWdata = 8'h00;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset();
    t_eq_biq();
    t_coef();
    t_paths();
    end_of_test();
  end
endmodule // pbfc_filter_ctrl_bench
`default_nettype wire
